/* rtl/ddrcmd_regs.vh */
`ifndef DDRCMD_REGS_VH
`define DDRCMD_REGS_VH
// bank address codes selecting a mode register
`define DDRCMD_BA_MODE_BASE 3'h0
`define DDRCMD_BA_MODE_ONE 3'h1
`define DDRCMD_BA_MODE_TWO 3'h2
`define DDRCMD_BA_MODE_THREE 3'h3
// field positions
`define DDRCMD_ADDR_W 14
`define DDRCMD_MR1_QOFF_BIT 12
`define DDRCMD_MR1_READ_STROBE_OPTION_BIT 11
`define DDRCMD_MR2_HOT_BIT 7
`define DDRCMD_AP_BIT 10
`define DDRCMD_ROW_TOP_BIT 13
// strobe patterns {cs, ras, cas, we}
`define DDRCMD_PAT_MRS 4'h0
`define DDRCMD_PAT_REF 4'h1
`define DDRCMD_PAT_PRE 4'h2
`define DDRCMD_PAT_ACT 4'h3
`define DDRCMD_PAT_WR 4'h4
`define DDRCMD_PAT_RD 4'h5
`define DDRCMD_PAT_NOP 4'h7
// decoded command codes
`define DDRCMD_C_NONE 4'h0
`define DDRCMD_C_MRS 4'h1
`define DDRCMD_C_REF 4'h2
`define DDRCMD_C_PRE 4'h3
`define DDRCMD_C_PREA 4'h4
`define DDRCMD_C_ACT 4'h5
`define DDRCMD_C_WR 4'h6
`define DDRCMD_C_WRA 4'h7
`define DDRCMD_C_RD 4'h8
`define DDRCMD_C_RDA 4'h9
`define DDRCMD_C_SRE 4'ha
`define DDRCMD_C_SRX 4'hb
`define DDRCMD_C_PDE 4'hc
`define DDRCMD_C_PDX 4'hd
`define DDRCMD_C_ILL 4'hf
// power states
`define DDRCMD_ST_ACT 2'h0
`define DDRCMD_ST_PD 2'h1
`define DDRCMD_ST_SR 2'h2
// reset values
`define DDRCMD_MR_RST 14'h0000
`endif

/* rtl/ddrcmd_decode.v */
// Operation
// - output disable stops data and strobe drive
// - top address bit only on by-8 parts
// - mode two selected by bank code two
// - mode rewrites accepted when all banks precharged
// - bit 7 enables hot_self_refresh_rate
// - mode three selected by bank code three
// - decode strobes and clock enable each edge
// - bank bits pick bank or mode register
// - four-beat bursts are not interrupted, except by self-refresh entry
// - self-refresh exit on clock enable rise
// - by-16 ignores top address bit on activate
`include "ddrcmd_regs.vh"
`default_nettype none
module ddrcmd_decode #(
    parameter IS_X16 = 0
) (
    input wire clk,
    input wire rst_n,
    input wire cke,
    input wire cs_n,
    input wire ras_n,
    input wire cas_n,
    input wire we_n,
    input wire [2:0] ba,
    input wire [13:0] addr,
    input wire banks_idle,
    input wire burst_busy,
    output reg [3:0] cmd_q,
    output reg [2:0] cmd_bank_q,
    output reg [13:0] cmd_addr_q,
    output reg [1:0] power_state_q,
    output reg [13:0] extended_mode_one_q,
    output reg [13:0] refresh_feature_mode_q,
    output reg [13:0] reserved_mode_three_q,
    output reg [13:0] base_mode_q,
    output reg output_off_q,
    output reg hot_self_refresh_rate_q,
    output reg illegal_q
);
    reg [3:0] cmd_d;
    reg [1:0] power_state_d;
    wire [3:0] pat;
    wire quiet;
    wire [13:0] addr_eff;

    // all commands come from levels at the rising edge
    assign pat = {cs_n, ras_n, cas_n, we_n};
    assign quiet = cs_n | (pat == `DDRCMD_PAT_NOP);
    // by-16 parts have no top address bit
    assign addr_eff = IS_X16 ? {1'b0, addr[`DDRCMD_ROW_TOP_BIT-1:0]} : addr;

    // command truth table; the power state stands in for the clock
    // enable of the previous edge, since it is only low in pd or sr
    always @* begin
        cmd_d = `DDRCMD_C_ILL;
        power_state_d = power_state_q;
        case (power_state_q)
            `DDRCMD_ST_PD: begin
                if (!cke) begin
                    // still asleep: pins are don't-care, nothing decoded
                    cmd_d = `DDRCMD_C_NONE;
                end else if (quiet) begin
                    cmd_d = `DDRCMD_C_PDX;
                    power_state_d = `DDRCMD_ST_ACT;
                end else begin
                    // waking with a real command is not in the table
                    cmd_d = `DDRCMD_C_ILL;
                end
            end
            `DDRCMD_ST_SR: begin
                if (!cke) begin
                    cmd_d = `DDRCMD_C_NONE;
                end else if (quiet) begin
                    // exit needs no clock history, one edge suffices
                    cmd_d = `DDRCMD_C_SRX;
                    power_state_d = `DDRCMD_ST_ACT;
                end else begin
                    cmd_d = `DDRCMD_C_ILL;
                end
            end
            default: begin
                if (!cke) begin
                    // power-down entry only with no burst in progress; self-refresh entry only with all banks idle
                    if (quiet && !burst_busy) begin
                        cmd_d = `DDRCMD_C_PDE;
                        power_state_d = `DDRCMD_ST_PD;
                    end else if (pat == `DDRCMD_PAT_REF && banks_idle) begin
                        cmd_d = `DDRCMD_C_SRE;
                        power_state_d = `DDRCMD_ST_SR;
                    end else begin
                        // any other edge with the clock enable falling
                        cmd_d = `DDRCMD_C_ILL;
                    end
                end else if (quiet) begin
                    cmd_d = `DDRCMD_C_NONE;
                end else if (burst_busy) begin
                    cmd_d = `DDRCMD_C_ILL; // four-beat burst stays whole
                end else begin
                    case (pat)
                        `DDRCMD_PAT_MRS: begin
                            // rewrites only with every bank precharged
                            if (banks_idle) begin
                                cmd_d = `DDRCMD_C_MRS;
                            end else begin
                                cmd_d = `DDRCMD_C_ILL;
                            end
                        end
                        `DDRCMD_PAT_REF: begin
                            cmd_d = `DDRCMD_C_REF;
                        end
                        `DDRCMD_PAT_PRE: begin
                            // ap bit widens the precharge to all banks
                            if (addr[`DDRCMD_AP_BIT]) begin
                                cmd_d = `DDRCMD_C_PREA;
                            end else begin
                                cmd_d = `DDRCMD_C_PRE;
                            end
                        end
                        `DDRCMD_PAT_ACT: begin
                            cmd_d = `DDRCMD_C_ACT;
                        end
                        `DDRCMD_PAT_WR: begin
                            // ap bit closes the row after the burst
                            if (addr[`DDRCMD_AP_BIT]) begin
                                cmd_d = `DDRCMD_C_WRA;
                            end else begin
                                cmd_d = `DDRCMD_C_WR;
                            end
                        end
                        `DDRCMD_PAT_RD: begin
                            if (addr[`DDRCMD_AP_BIT]) begin
                                cmd_d = `DDRCMD_C_RDA;
                            end else begin
                                cmd_d = `DDRCMD_C_RD;
                            end
                        end
                        default: begin
                            cmd_d = `DDRCMD_C_ILL;
                        end
                    endcase
                end
            end
        endcase
    end

    // registered decode and power state
    always @(posedge clk) begin
        if (!rst_n) begin
            cmd_q <= `DDRCMD_C_NONE;
            power_state_q <= `DDRCMD_ST_ACT;
        end else begin
            cmd_q <= cmd_d;
            power_state_q <= power_state_d;
        end
    end

    // bank and address of every edge; bank or mode register select
    always @(posedge clk) begin
        if (!rst_n) begin
            cmd_bank_q <= 3'h0;
            cmd_addr_q <= `DDRCMD_MR_RST;
        end else begin
            cmd_bank_q <= ba;
            cmd_addr_q <= addr_eff;
        end
    end

    // fault flag: sticky, since recovery needs a full power-down and
    // reinit; nothing but reset may clear it
    always @(posedge clk) begin
        if (!rst_n) begin
            illegal_q <= 1'b0;
        end else if (cmd_d == `DDRCMD_C_ILL) begin
            illegal_q <= 1'b1;
        end
    end

    // mode register writes; contents reset to zero until programmed
    always @(posedge clk) begin
        if (!rst_n) begin
            base_mode_q <= `DDRCMD_MR_RST;
            extended_mode_one_q <= `DDRCMD_MR_RST;
            refresh_feature_mode_q <= `DDRCMD_MR_RST;
            reserved_mode_three_q <= `DDRCMD_MR_RST;
            output_off_q <= 1'b0;
            hot_self_refresh_rate_q <= 1'b0;
        end else if (cmd_d == `DDRCMD_C_MRS) begin
            case (ba)
                `DDRCMD_BA_MODE_BASE: begin
                    // base register kept only so rewrites are visible
                    base_mode_q <= addr_eff;
                end
                `DDRCMD_BA_MODE_ONE: begin
                    extended_mode_one_q <= addr_eff;
                    // output disable floats dq, dqs and read strobes
                    output_off_q <= addr_eff[`DDRCMD_MR1_QOFF_BIT];
                end
                `DDRCMD_BA_MODE_TWO: begin
                    refresh_feature_mode_q <= addr_eff;
                    hot_self_refresh_rate_q <= addr_eff[`DDRCMD_MR2_HOT_BIT];
                end
                `DDRCMD_BA_MODE_THREE: begin
                    // no function yet; stored so the host can be checked
                    reserved_mode_three_q <= addr_eff;
                end
                default: begin
                    base_mode_q <= base_mode_q; // unused codes ignored
                end
            endcase
        end
    end
endmodule
`default_nettype wire

/* verif/ddrcmd_ctrl_model.sv */
`default_nettype none
module ddrcmd_ctrl_model #(parameter int MRD = 2) (
    input wire logic clk,
    output logic cke,
    output logic [3:0] cmd,
    output logic [2:0] ba,
    output logic [13:0] addr
);
    timeunit 1ns;
    timeprecision 100ps;
    // power up with the clock enable low and a no-op on the strobes
    initial begin
        {cke, cmd, ba, addr} = {1'b0, 4'h7, 3'h0, 14'h0000};
    end
    // one command per edge, launched just after the edge
    task automatic issue(input logic k, input logic [3:0] c, input logic [2:0] b,
        input logic [13:0] a);
        @(posedge clk);
        #1;
        {cke, cmd, ba, addr} = {k, c, b, a};
    endtask
    // idle lines flip so a stale address never looks held
    task automatic quiet(input logic k);
        issue(k, 4'h7, ~ba, ~addr);
    endtask
    task automatic mrs(input logic [2:0] b, input logic [13:0] a);
        issue(1'b1, 4'h0, b, a);
        repeat (MRD) quiet(1'b1);
    endtask
    task automatic init();
        issue(1'b1, 4'h7, 3'h0, 14'h0000);
        mrs(3'h2, 14'h0000);
        mrs(3'h3, 14'h0000);
        mrs(3'h1, 14'h0000);
    endtask
endmodule
`default_nettype wire

/* verif/ddrcmd_decode_checker.sv */
`include "ddrcmd_regs.vh"
`default_nettype none
module ddrcmd_decode_checker (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [2:0] ba,
    input wire logic [13:0] addr,
    input wire logic banks_idle,
    input wire logic burst_busy,
    input wire logic [3:0] cmd_q,
    input wire logic [2:0] cmd_bank_q,
    input wire logic [13:0] cmd_addr_q,
    input wire logic [1:0] power_state_q,
    input wire logic [13:0] refresh_feature_mode_q,
    input wire logic output_off_q,
    input wire logic hot_self_refresh_rate_q,
    input wire logic illegal_q
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    // live: an ordinary command may run this edge
    wire logic [3:0] pat = {cs_n, ras_n, cas_n, we_n};
    wire logic act = power_state_q == `DDRCMD_ST_ACT;
    wire logic live = cke && act && !burst_busy;
    wire logic mrs = live && pat == `DDRCMD_PAT_MRS;
    a_mode_two_load: assert property (mrs && banks_idle && ba == 3'h2 |=>
        refresh_feature_mode_q == $past(addr) && hot_self_refresh_rate_q == $past(addr[7]))
        else $error("mode two not loaded");
    a_output_off_bit: assert property (mrs && banks_idle && ba == 3'h1 |=>
        output_off_q == $past(addr[12])) else $error("output disable wrong");
    a_mrs_refused: assert property (mrs && !banks_idle |=>
        cmd_q == `DDRCMD_C_ILL && illegal_q) else $error("busy mode write taken");
    a_illegal_sticky: assert property (illegal_q |=> illegal_q)
        else $error("fault flag dropped");
    a_burst_guard: assert property (cke && act && burst_busy && !cs_n && pat != 4'h7
        |=> cmd_q == `DDRCMD_C_ILL) else $error("burst interrupted");
    a_activate_bank: assert property (live && pat == `DDRCMD_PAT_ACT |=>
        cmd_q == `DDRCMD_C_ACT && cmd_bank_q == $past(ba)) else $error("activate wrong");
    a_self_entry: assert property (!cke && act && pat == `DDRCMD_PAT_REF && banks_idle
        && !burst_busy |=> cmd_q == `DDRCMD_C_SRE && power_state_q == `DDRCMD_ST_SR)
        else $error("self refresh entry wrong");
    a_self_exit: assert property (power_state_q == `DDRCMD_ST_SR && cke && cs_n |=>
        cmd_q == `DDRCMD_C_SRX && act) else $error("self refresh exit wrong");
    a_addr_capture: assert property (rst_n |=> cmd_addr_q == $past(addr))
        else $error("address not captured");
    c_mode_write: cover property (mrs && banks_idle);
    c_self_refresh: cover property (power_state_q == `DDRCMD_ST_SR);
    c_fault: cover property (illegal_q);
endmodule
bind ddrcmd_decode ddrcmd_decode_checker u_chk (.*);
`default_nettype wire

/* verif/ddrcmd_decode_test.sv */
`default_nettype none
module ddrcmd_decode_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic banks_idle = 1'b1;
    logic burst_busy = 1'b0;
    logic cke, hot_q, off_q, ill_q;
    logic [3:0] cmd, cmd_q;
    logic [2:0] ba;
    logic [1:0] st_q;
    logic [13:0] addr, rf_q, m1_q, addr_q;
    int miscompares = 0;
    int comparisons = 0;
    logic [3:0] pt [8] = '{4'h3, 4'h4, 4'h4, 4'h5, 4'h5, 4'h2, 4'h2, 4'h1};
    logic [13:0] ad [8] = '{14'h2000, 0, 14'h0400, 0, 14'h0400, 0, 14'h0400, 0};
    logic [3:0] ex [8] = '{4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'h3, 4'h4, 4'h2};
    always #5 clk = ~clk;
    ddrcmd_ctrl_model u_ctl (.clk, .cke, .cmd, .ba, .addr);
    ddrcmd_decode u_dut (.clk, .rst_n, .cke, .cs_n(cmd[3]), .ras_n(cmd[2]), .cas_n(cmd[1]),
        .we_n(cmd[0]), .ba, .addr, .banks_idle, .burst_busy, .cmd_q, .cmd_bank_q(),
        .cmd_addr_q(addr_q), .power_state_q(st_q), .extended_mode_one_q(m1_q),
        .refresh_feature_mode_q(rf_q), .reserved_mode_three_q(), .base_mode_q(),
        .output_off_q(off_q), .hot_self_refresh_rate_q(hot_q), .illegal_q(ill_q));
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // decoded code shows right after the same edge that takes the command
    task automatic cmd_chk(input logic k, input logic [3:0] c, input logic [2:0] b,
        input logic [13:0] a, input logic [3:0] e);
        u_ctl.issue(k, c, b, a);
        u_ctl.quiet(k);
        chk({10'h000, cmd_q}, {10'h000, e});
    endtask
    task automatic print_verdict();
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // refusals run last because the fault flag only clears on reset
    initial begin
        repeat (10) @(posedge clk);
        #1;
        rst_n = 1'b1;
        u_ctl.init();
        chk({13'h0000, ill_q}, 14'h0000);
        cmd_chk(1'b1, 4'h0, 3'h2, 14'h0080, 4'h1);
        chk({rf_q[13:1], hot_q}, 14'h0081);
        cmd_chk(1'b1, 4'h0, 3'h2, 14'h0000, 4'h1);
        chk({13'h0000, hot_q}, 14'h0000);
        cmd_chk(1'b1, 4'h0, 3'h1, 14'h1000, 4'h1);
        chk({13'h0000, off_q}, 14'h0001);
        chk(m1_q, 14'h1000);
        cmd_chk(1'b1, 4'h3, 3'h5, 14'h2000, 4'h5);
        chk(addr_q, 14'h2000);
        for (int i = 0; i < 8; i++) cmd_chk(1'b1, pt[i], 3'h5, ad[i], ex[i]);
        cmd_chk(1'b0, 4'h7, 3'h0, 14'h0000, 4'hc);
        chk({12'h000, st_q}, 14'h0001);
        cmd_chk(1'b0, 4'h7, 3'h0, 14'h0000, 4'h0);
        cmd_chk(1'b1, 4'h7, 3'h0, 14'h0000, 4'hd);
        cmd_chk(1'b0, 4'h1, 3'h0, 14'h0000, 4'ha);
        cmd_chk(1'b1, 4'hf, 3'h0, 14'h0000, 4'hb);
        banks_idle = 1'b0;
        cmd_chk(1'b1, 4'h0, 3'h2, 14'h0000, 4'hf);
        chk({13'h0000, ill_q}, 14'h0001);
        banks_idle = 1'b1;
        burst_busy = 1'b1;
        cmd_chk(1'b1, 4'h5, 3'h0, 14'h0000, 4'hf);
        print_verdict();
    end
endmodule
`default_nettype wire
